// *** hdl/lpcg_cfg.svh ***
// offsets, field positions and reset values of the low power clock gating bank
`ifndef LPCG_CFG_SVH
`define LPCG_CFG_SVH

`define LPCG_OFS_RUN    12'h100
`define LPCG_OFS_SLP    12'h110
`define LPCG_OFS_DSL    12'h120
`define LPCG_OFS_CFG    12'h060
`define LPCG_OFS_ISTS   12'h140
`define LPCG_OFS_IMSK   12'h144

`define LPCG_GATE_RST   32'h0000_0040
`define LPCG_GATE_WMASK 32'h0010_0048
`define LPCG_BIT_WATCHDOG    3
`define LPCG_BIT_HIBERNATION 6
`define LPCG_BIT_PWM         20

`define LPCG_CFG_RST    32'h0000_0000
`define LPCG_CFG_WMASK  32'h0000_0001
`define LPCG_CFG_AUTO_GATING_SELECT 0

`define LPCG_EV_FAULT   0
`define LPCG_EV_CHG     1
`define LPCG_EV_WMASK   32'h0000_0003

`endif

// *** hdl/lpcg_pkg.sv ***
// types shared by the low power clock gating bank
`include "lpcg_cfg.svh"
package lpcg_pkg;

	typedef enum logic [1:0] {
		ps_run,
		ps_sleep,
		ps_deep
	} lpcg_pstate_t;

	typedef enum logic [1:0] {
		unit_watchdog,
		unit_hibernation,
		unit_pwm
	} lpcg_unit_t;

	typedef struct packed {
		logic pwm;
		logic hibernation_gate;
		logic watchdog_gate;
	} lpcg_gates_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} lpcg_bus_req_t;

	// pull the unit enables out of a gating register word
	function automatic lpcg_gates_t lpcg_to_gates(input logic [31:0] w);
		lpcg_gates_t g;
		g.pwm              = w[`LPCG_BIT_PWM];
		g.hibernation_gate = w[`LPCG_BIT_HIBERNATION];
		g.watchdog_gate    = w[`LPCG_BIT_WATCHDOG];
		return g;
	endfunction

	// address match for one register
	function automatic logic lpcg_hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

endpackage

// *** hdl/lpcg_gate_sel.sv ***
// picks the gating set that applies in the present power state
`timescale 1ns/1ns
`include "lpcg_cfg.svh"
module lpcg_gate_sel (
	input  wire lpcg_pkg::lpcg_pstate_t pstate,
	input  wire logic                   auto_gating_select,
	input  wire lpcg_pkg::lpcg_gates_t  run_set,
	input  wire lpcg_pkg::lpcg_gates_t  slp_set,
	input  wire lpcg_pkg::lpcg_gates_t  dsl_set,
	output      lpcg_pkg::lpcg_gates_t  eff_set
);
	import lpcg_pkg::*;

	// low power sets only count when software opted into sleep gating
	always_comb begin
		unique case (pstate)
			ps_run:   eff_set = run_set;
			ps_sleep: eff_set = auto_gating_select ? slp_set : run_set;
			ps_deep:  eff_set = auto_gating_select ? dsl_set : run_set;
			default:  eff_set = run_set;
		endcase
	end

endmodule

// *** hdl/lpcg_bank.sv ***
// low power clock gating bank: gating registers, enable select, fault check, interrupt
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "lpcg_cfg.svh"
module lpcg_bank (
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	input  wire lpcg_pkg::lpcg_bus_req_t bus_req,
	output      logic [31:0]            bus_rdata_ff,
	input  wire logic                   pwr_sleep,
	input  wire logic                   pwr_deep,
	input  wire logic                   unit_acc_valid,
	input  wire lpcg_pkg::lpcg_unit_t   unit_acc_sel,
	output      logic                   unit_acc_done_ff,
	output      logic                   unit_fault_ff,
	output      lpcg_pkg::lpcg_gates_t  unit_clk_en_ff,
	output      logic                   irq_ff
);
	import lpcg_pkg::*;

	logic [31:0]  run_gate_ff;
	logic [31:0]  slp_gate_ff;
	logic [31:0]  dsl_gate_ff;
	logic [31:0]  cfg_ff;
	logic [31:0]  ists_ff;
	logic [31:0]  imsk_ff;
	logic [31:0]  nxt_ists;
	logic [31:0]  nxt_rdata;
	logic [31:0]  ev;
	lpcg_pstate_t pstate;
	lpcg_gates_t  nxt_gates;
	logic         unit_on;
	logic         acc_bad;
	logic         boot_ff;

	// deep sleep outranks sleep if the controller raises both
	always_comb begin
		if (pwr_deep) begin
			pstate = ps_deep;
		end else if (pwr_sleep) begin
			pstate = ps_sleep;
		end else begin
			pstate = ps_run;
		end
	end

	// run gating register, same layout as the low power ones
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			run_gate_ff <= `LPCG_GATE_RST;
		end else if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_RUN)) begin
			run_gate_ff <= bus_req.wdata & `LPCG_GATE_WMASK;
		end
	end

	// sleep gating register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slp_gate_ff <= `LPCG_GATE_RST;
		end else if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_SLP)) begin
			slp_gate_ff <= bus_req.wdata & `LPCG_GATE_WMASK;
		end
	end

	// deep-sleep gating register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dsl_gate_ff <= `LPCG_GATE_RST;
		end else if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_DSL)) begin
			dsl_gate_ff <= bus_req.wdata & `LPCG_GATE_WMASK;
		end
	end

	// clock configuration: only the automatic gating select is kept here
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_ff <= `LPCG_CFG_RST;
		end else if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_CFG)) begin
			cfg_ff <= bus_req.wdata & `LPCG_CFG_WMASK;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			imsk_ff <= 32'h0000_0000;
		end else if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_IMSK)) begin
			imsk_ff <= bus_req.wdata & `LPCG_EV_WMASK;
		end
	end

	lpcg_gate_sel u_sel (
		.pstate             (pstate),
		.auto_gating_select (cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]),
		.run_set            (lpcg_to_gates(run_gate_ff)),
		.slp_set            (lpcg_to_gates(slp_gate_ff)),
		.dsl_set            (lpcg_to_gates(dsl_gate_ff)),
		.eff_set            (nxt_gates)
	);

	// enables leave on flops so the unit clock gates see no glitches
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			unit_clk_en_ff <= '0;
		end else begin
			unit_clk_en_ff <= nxt_gates;
		end
	end

	// judge against the enables the units really have right now
	always_comb begin
		case (unit_acc_sel)
			unit_watchdog:    unit_on = unit_clk_en_ff.watchdog_gate;
			unit_hibernation: unit_on = unit_clk_en_ff.hibernation_gate;
			unit_pwm:         unit_on = unit_clk_en_ff.pwm;
			default:          unit_on = 1'b0;
		endcase
	end

	assign acc_bad = unit_acc_valid && !unit_on;

	// one answer per access: either completed or faulted, never both
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			unit_fault_ff    <= 1'b0;
			unit_acc_done_ff <= 1'b0;
		end else begin
			unit_fault_ff    <= acc_bad;
			unit_acc_done_ff <= unit_acc_valid && unit_on;
		end
	end

	// sticky events; a new event beats a same-cycle clear
	always_comb begin
		ev = 32'h0000_0000;
		ev[`LPCG_EV_FAULT] = acc_bad;
		ev[`LPCG_EV_CHG]   = nxt_gates != unit_clk_en_ff;
		nxt_ists = ists_ff;
		if (bus_req.wr && lpcg_hit(bus_req.addr, `LPCG_OFS_ISTS)) begin
			nxt_ists = ists_ff & ~bus_req.wdata;
		end
		nxt_ists = nxt_ists | ev;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ists_ff <= 32'h0000_0000;
		end else begin
			ists_ff <= nxt_ists;
		end
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(ists_ff & imsk_ff);
		end
	end

	// read mux; unmapped and reserved bits read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`LPCG_OFS_RUN:  nxt_rdata = run_gate_ff;
				`LPCG_OFS_SLP:  nxt_rdata = slp_gate_ff;
				`LPCG_OFS_DSL:  nxt_rdata = dsl_gate_ff;
				`LPCG_OFS_CFG:  nxt_rdata = cfg_ff;
				`LPCG_OFS_ISTS: nxt_rdata = ists_ff;
				`LPCG_OFS_IMSK: nxt_rdata = imsk_ff;
				default:        nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rdata_ff <= 32'h0000_0000;
		end else begin
			bus_rdata_ff <= nxt_rdata;
		end
	end

	// marks the first clocked cycle after reset, for checking only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_ff <= 1'b0;
		end else begin
			boot_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// checks
	AST_RESET_VALS: assert property (
		!boot_ff |-> run_gate_ff == `LPCG_GATE_RST && slp_gate_ff == `LPCG_GATE_RST
			&& dsl_gate_ff == `LPCG_GATE_RST && cfg_ff == `LPCG_CFG_RST)
		else $error("gating registers not at reset value");

	AST_RUN_SET: assert property (
		pstate == ps_run |=> unit_clk_en_ff == $past(lpcg_to_gates(run_gate_ff)))
		else $error("run set not applied while running");

	AST_LP_SET: assert property (
		pstate == ps_deep && cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]
		|=> unit_clk_en_ff == $past(lpcg_to_gates(dsl_gate_ff)))
		else $error("deep-sleep set not applied");

	AST_SLP_SET: assert property (
		pstate == ps_sleep && cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]
		|=> unit_clk_en_ff == $past(lpcg_to_gates(slp_gate_ff)))
		else $error("sleep set not applied");

	AST_NO_AUTO_SEL: assert property (
		pstate != ps_run && !cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]
		|=> unit_clk_en_ff == $past(lpcg_to_gates(run_gate_ff)))
		else $error("low power set used without gating select");

	// every unit must fault while stopped, whichever one is addressed
	AST_FAULT: assert property (
		unit_acc_valid && unit_acc_sel == unit_watchdog
			&& !unit_clk_en_ff.watchdog_gate
		|=> unit_fault_ff && !unit_acc_done_ff)
		else $error("access to stopped unit not faulted");

	AST_FAULT_HIB: assert property (
		unit_acc_valid && unit_acc_sel == unit_hibernation
			&& !unit_clk_en_ff.hibernation_gate
		|=> unit_fault_ff && !unit_acc_done_ff)
		else $error("access to stopped hibernation unit not faulted");

	AST_FAULT_PWM: assert property (
		unit_acc_valid && unit_acc_sel == unit_pwm && !unit_clk_en_ff.pwm
		|=> unit_fault_ff && !unit_acc_done_ff)
		else $error("access to stopped modulator not faulted");

	AST_NO_FAULT: assert property (
		unit_acc_valid && unit_acc_sel == unit_pwm && unit_clk_en_ff.pwm
		|=> !unit_fault_ff && unit_acc_done_ff)
		else $error("access to clocked unit faulted");

	AST_DONE_WDT: assert property (
		unit_acc_valid && unit_acc_sel == unit_watchdog
			&& unit_clk_en_ff.watchdog_gate
		|=> !unit_fault_ff && unit_acc_done_ff)
		else $error("access to clocked watchdog faulted");

	AST_ONE_ANSWER: assert property (
		!(unit_fault_ff && unit_acc_done_ff))
		else $error("access both completed and faulted");

	// run and sleep writes land whole, reserved bits dropped; deep-sleep writes are checked on the pwm and hibernation bits
	AST_WR_RUN: assert property (
		bus_req.wr && bus_req.addr == `LPCG_OFS_RUN
		|=> run_gate_ff == ($past(bus_req.wdata) & `LPCG_GATE_WMASK))
		else $error("run gating write lost");

	AST_WR_SLP: assert property (
		bus_req.wr && bus_req.addr == `LPCG_OFS_SLP
		|=> slp_gate_ff == ($past(bus_req.wdata) & `LPCG_GATE_WMASK))
		else $error("sleep gating write lost");

	AST_WR_DSL: assert property (
		bus_req.wr && bus_req.addr == `LPCG_OFS_DSL
		|=> dsl_gate_ff[`LPCG_BIT_PWM] == $past(bus_req.wdata[`LPCG_BIT_PWM])
			&& dsl_gate_ff[`LPCG_BIT_HIBERNATION]
			== $past(bus_req.wdata[`LPCG_BIT_HIBERNATION]))
		else $error("deep-sleep enable bits not stored");

	AST_RSVD: assert property (
		bus_req.rd && (bus_req.addr == `LPCG_OFS_SLP || bus_req.addr == `LPCG_OFS_DSL)
		|=> (bus_rdata_ff & ~`LPCG_GATE_WMASK) == 32'h0000_0000)
		else $error("reserved gating bits read nonzero");

	AST_RD_SLP: assert property (
		bus_req.rd && bus_req.addr == `LPCG_OFS_SLP |=> bus_rdata_ff == $past(slp_gate_ff))
		else $error("sleep register read wrong");

	AST_RD_DSL: assert property (
		bus_req.rd && bus_req.addr == `LPCG_OFS_DSL |=> bus_rdata_ff == $past(dsl_gate_ff))
		else $error("deep-sleep register read wrong");

	// read data must not linger, software would see stale words
	AST_RD_IDLE: assert property (
		!bus_req.rd |=> bus_rdata_ff == 32'h0000_0000)
		else $error("read data outside its cycle");

	// status is sticky and the event beats a clear in the same cycle
	AST_FAULT_STICKY: assert property (
		acc_bad |=> ists_ff[`LPCG_EV_FAULT])
		else $error("fault event lost");

	AST_CHG_EVENT: assert property (
		unit_clk_en_ff != $past(unit_clk_en_ff) |-> ists_ff[`LPCG_EV_CHG])
		else $error("enable change not flagged");

	AST_IRQ: assert property (
		acc_bad && imsk_ff[`LPCG_EV_FAULT] |=> ##1 irq_ff)
		else $error("fault event raised no interrupt");

	AST_IRQ_QUIET: assert property (
		(ists_ff & imsk_ff) == 32'h0000_0000 |=> !irq_ff)
		else $error("interrupt without unmasked status");

	// main scenarios
	COV_FAULT:   cover property (unit_acc_valid && !unit_on ##1 unit_fault_ff);
	COV_DONE:    cover property (unit_acc_valid && unit_on ##1 unit_acc_done_ff);
	COV_SLEEP:   cover property (pstate == ps_sleep && cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]);
	COV_NO_AUTO: cover property (pstate != ps_run && !cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT]);
	COV_DEEP:    cover property (
		pstate == ps_deep && cfg_ff[`LPCG_CFG_AUTO_GATING_SELECT] ##1 irq_ff);

endmodule

// *** verification/lpcg_unit_model.sv ***
// far side model: gated units that advance only while their clock enable is high
`timescale 1ns/1ns
module lpcg_unit_model (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire lpcg_pkg::lpcg_gates_t clk_en,
	output      logic [2:0][7:0]       ticks_ff
);
	import lpcg_pkg::*;
	logic [2:0] en;
	assign en = clk_en;
	// a unit with its clock withheld must not move at all
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ticks_ff <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				ticks_ff[i] <= ticks_ff[i] + {7'h0, en[i]};
			end
		end
	end
endmodule

// *** verification/tb_low_power_clock_gating_bank.sv ***
// self-checking bench for the low power clock gating bank
`timescale 1ns/1ns
`include "lpcg_cfg.svh"
module tb_low_power_clock_gating_bank;
	import lpcg_pkg::*;
	logic            mclk = 1'b0;
	logic            sys_rst;
	lpcg_bus_req_t   bus_req;
	logic [31:0]     bus_rdata_ff;
	logic            pwr_sleep;
	logic            pwr_deep;
	logic            unit_acc_valid;
	lpcg_unit_t      unit_acc_sel;
	logic            unit_acc_done_ff;
	logic            unit_fault_ff;
	lpcg_gates_t     unit_clk_en_ff;
	logic            irq_ff;
	logic [2:0][7:0] ticks;
	logic [7:0]      t0;
	logic [23:0]     t_all;
	logic [31:0]     rs, ss, ds, cf, r;
	logic [1:0]      k;
	lpcg_gates_t     g;
	int              failures = 0;
	int              samples_checked = 0;

	lpcg_bank dut_u (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_rdata_ff(bus_rdata_ff), .pwr_sleep(pwr_sleep), .pwr_deep(pwr_deep),
		.unit_acc_valid(unit_acc_valid), .unit_acc_sel(unit_acc_sel),
		.unit_acc_done_ff(unit_acc_done_ff), .unit_fault_ff(unit_fault_ff),
		.unit_clk_en_ff(unit_clk_en_ff), .irq_ff(irq_ff));
	lpcg_unit_model far_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(unit_clk_en_ff),
		.ticks_ff(ticks));

	always #50 mclk = ~mclk;

	// enable set expected from the registers written and the power state
	function automatic lpcg_gates_t exp_en(input logic [31:0] rw, sw, dw,
			input logic slp, dp, auto_sel);
		logic [31:0] w;
		w = (auto_sel & dp) ? dw : (auto_sel & slp) ? sw : rw;
		return {w[`LPCG_BIT_PWM], w[`LPCG_BIT_HIBERNATION], w[`LPCG_BIT_WATCHDOG]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus_req <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge mclk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge mclk);
		bus_req <= '0;
		#1 check(bus_rdata_ff, exp);
	endtask

	// one access to a unit; stopped units must fault, clocked ones complete
	task automatic acc(input logic [1:0] s, input logic [2:0] gv);
		@(posedge mclk);
		unit_acc_valid <= 1'b1;
		unit_acc_sel <= lpcg_unit_t'(s);
		@(posedge mclk);
		unit_acc_valid <= 1'b0;
		#1 check({31'h0, unit_fault_ff}, {31'h0, ~gv[s]});
		check({31'h0, unit_acc_done_ff}, {31'h0, gv[s]});
	endtask

	task automatic stop_test();
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watchdog sized well beyond the roughly 860 cycles the sequence needs
	initial begin
		#(100 * 6000);
		failures++;
		stop_test();
	end

	initial begin
		void'($urandom(32'he1bac296));
		sys_rst = 1'b1;
		bus_req = '0;
		pwr_sleep = 1'b0;
		pwr_deep = 1'b0;
		unit_acc_valid = 1'b0;
		unit_acc_sel = unit_watchdog;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1 check({29'h0, unit_clk_en_ff}, 32'h2);
		rd(`LPCG_OFS_RUN, `LPCG_GATE_RST);
		rd(`LPCG_OFS_SLP, `LPCG_GATE_RST);
		rd(`LPCG_OFS_DSL, `LPCG_GATE_RST);
		rd(12'h0ff, 32'h0);
		// random register contents and power states, all ones in run and sleep first and in deep-sleep second as a corner
		for (int i = 0; i < 40; i++) begin
			rs = (i == 0) ? '1 : $urandom;
			ss = (i == 0) ? '1 : $urandom;
			ds = (i == 1) ? '1 : $urandom;
			cf = $urandom;
			r = $urandom;
			wr(`LPCG_OFS_RUN, rs);
			wr(`LPCG_OFS_SLP, ss);
			wr(`LPCG_OFS_DSL, ds);
			wr(`LPCG_OFS_CFG, cf);
			rd(`LPCG_OFS_RUN, rs & `LPCG_GATE_WMASK);
			rd(`LPCG_OFS_SLP, ss & `LPCG_GATE_WMASK);
			rd(`LPCG_OFS_DSL, ds & `LPCG_GATE_WMASK);
			@(posedge mclk);
			pwr_sleep <= r[0];
			pwr_deep <= r[1];
			repeat (3) @(posedge mclk);
			g = exp_en(rs, ss, ds, r[0], r[1], cf[0]);
			#1 check({29'h0, unit_clk_en_ff}, {29'h0, g});
			k = (r[5:4] == 2'h3) ? 2'h0 : r[5:4];
			acc(k, g);
		end
		// all units stopped, then a fault raises the interrupt
		@(posedge mclk);
		pwr_sleep <= 1'b0;
		pwr_deep <= 1'b0;
		wr(`LPCG_OFS_CFG, 32'h0);
		wr(`LPCG_OFS_RUN, 32'h0);
		repeat (3) @(posedge mclk);
		wr(`LPCG_OFS_ISTS, 32'h3);
		rd(`LPCG_OFS_ISTS, 32'h0);
		wr(`LPCG_OFS_IMSK, 32'h1);
		acc(2'h0, 3'h0);
		@(posedge mclk);
		#1 check({31'h0, irq_ff}, 32'h1);
		rd(`LPCG_OFS_ISTS, 32'h1);
		wr(`LPCG_OFS_IMSK, 32'h0);
		repeat (2) @(posedge mclk);
		#1 check({31'h0, irq_ff}, 32'h0);
		// stopped units hold still, a clocked watchdog advances once per cycle
		t0 = ticks[0];
		t_all = ticks;
		repeat (5) @(posedge mclk);
		#1 check({24'h0, ticks[0]}, {24'h0, t0});
		check({8'h0, ticks}, {8'h0, t_all});
		wr(`LPCG_OFS_RUN, 32'h8);
		repeat (3) @(posedge mclk);
		#1 t0 = ticks[0];
		repeat (5) @(posedge mclk);
		#1 check({24'h0, ticks[0]}, {24'h0, t0 + 8'h5});
		// the enable change flags its own status bit beside the old fault
		rd(`LPCG_OFS_ISTS, 32'h3);
		acc(2'h0, 3'h1);
		stop_test();
	end
endmodule
